// ---- design/iap_flash_pkg.sv ----
// Constants, timing figures and state codes for the flash programming controller.
// Assumes a 10 MHz system clock and a 15-bit word address into the program flash.
package iap_flash_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 15;
   localparam int ADDR_HIGH_W = 7;
   localparam int PAGE_W = 6;
   localparam int BUF_WORDS = 64;
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int CNT_W = 20;

   // ----------------------------------------------------------------
   // Operation mode codes
   // ----------------------------------------------------------------
   localparam logic [2:0] MODE_WRITE = 3'h0;
   localparam logic [2:0] MODE_ERASE = 3'h1;
   localparam logic [2:0] MODE_READ = 3'h3;
   localparam logic [2:0] MODE_UNLOCK = 3'h6;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 10;
   localparam int EW_TIME_FAST_US = 2000;
   localparam int EW_TIME_SLOW_US = 4000;
   localparam int UNLOCK_WINDOW_US = 1000;
   localparam int READ_INSTR_CYCLES = 3;
   localparam int CLKS_PER_INSTR = 4;
   localparam int EW_FAST_CLKS = EW_TIME_FAST_US * CLK_MHZ;
   localparam int EW_SLOW_CLKS = EW_TIME_SLOW_US * CLK_MHZ;
   localparam int UNLOCK_CLKS = UNLOCK_WINDOW_US * CLK_MHZ;
   localparam int READ_CLKS = READ_INSTR_CYCLES * CLKS_PER_INSTR;

   // ----------------------------------------------------------------
   // Unlock pattern, in order of entry
   // ----------------------------------------------------------------
   localparam int UNLOCK_LEN = 6;
   localparam logic [BYTE_W-1:0] UNLOCK_B0 = 8'h00;
   localparam logic [BYTE_W-1:0] UNLOCK_B1 = 8'h0D;
   localparam logic [BYTE_W-1:0] UNLOCK_B2 = 8'hC3;
   localparam logic [BYTE_W-1:0] UNLOCK_B3 = 8'h04;
   localparam logic [BYTE_W-1:0] UNLOCK_B4 = 8'h09;
   localparam logic [BYTE_W-1:0] UNLOCK_B5 = 8'h40;

   function automatic logic [BYTE_W-1:0] unlock_byte(input logic [2:0] idx);
      case (idx)
         3'h0: unlock_byte = UNLOCK_B0;
         3'h1: unlock_byte = UNLOCK_B1;
         3'h2: unlock_byte = UNLOCK_B2;
         3'h3: unlock_byte = UNLOCK_B3;
         3'h4: unlock_byte = UNLOCK_B4;
         default: unlock_byte = UNLOCK_B5;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_ERASE = 5'h02,
      ST_PROG = 5'h04,
      ST_HOLD = 5'h08,
      ST_READ = 5'h10
   } seq_state_t;

endpackage

// ---- design/cycle_timer.sv ----
// Down-counting one-shot timer: a done pulse a loaded number of cycles after start.
// Assumes start and count come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module cycle_timer #(
   parameter int CNT_W = 20
) (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic start_i,
   input wire logic [CNT_W-1:0] count_i,
   output logic busy_o,
   output logic done_o
);

   // ----------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------
   if (CNT_W < 2 || CNT_W > 31) begin : g_bad_width
      $error("cycle_timer: CNT_W out of range");
   end

   logic [CNT_W-1:0] remain;

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         remain <= '0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else if (start_i) begin
         remain <= (count_i == '0) ? CNT_W'(1) : count_i;
         busy_o <= 1'b1;
         done_o <= 1'b0;
      end else if (busy_o && remain == CNT_W'(1)) begin
         remain <= '0;
         busy_o <= 1'b0;
         done_o <= 1'b1;
      end else begin
         remain <= busy_o ? remain - CNT_W'(1) : remain;
         done_o <= 1'b0;
      end
   end

endmodule // cycle_timer

`default_nettype wire

// ---- design/iap_flash_program_control.sv ----
// Flash programming controller: unlock, page erase, buffered page write and word read.
// Assumes CPU-side write strobes and the flash array all run on clk_sys_i.
//
// Summary of operation
// - Mode 000 selects write: buffer contents go to flash on trigger.
// - Buffer-clear empties the page write buffer for fresh data.
// - Trigger bit starts erase or write; device clears it when done.
// - Erase targets page from address registers, tagged by dummy high-byte writes.
// - Erase always clears the entire page, never single words.
// - Write commits whole buffer as one page; addressing stays inside page.
// - After failed verify, rewrite same page without erase is accepted.
// - CPU is stalled while an erase, write or read runs.
// - Erase and write duration chosen by the time-select bit.
// - Erase and write refused unless erase/write enabled status is high.
// - Clearing enabled status leaves enabled mode, blocking erase and write.
// - Mode 011 with read-enable high is needed to trigger a read.
// - Read fetches addressed word into data registers and clears trigger on the same clock edge.
// - Read trigger returns low about three instruction cycles after set.
// - Reads work with or without the erase/write unlock.
// - Mode 110 plus protect-enable starts unlock timer; expiry clears protect-enable.
// - Correct six-byte pattern in order sets erase/write enabled status.
// - Buffer holds 64 words; pointer increments per word, stops at page end.
`timescale 1ns/1ps
`default_nettype none

module iap_flash_program_control #(
   parameter int BUF_WORDS = iap_flash_pkg::BUF_WORDS,
   parameter int EW_FAST_CLKS = iap_flash_pkg::EW_FAST_CLKS,
   parameter int EW_SLOW_CLKS = iap_flash_pkg::EW_SLOW_CLKS,
   parameter int UNLOCK_CLKS = iap_flash_pkg::UNLOCK_CLKS,
   parameter int READ_CLKS = iap_flash_pkg::READ_CLKS
) (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic [2:0] op_mode_field_i,
   input wire logic erase_write_time_select_i,
   input wire logic read_enable_bit_i,
   input wire logic buffer_clear_bit_i,
   input wire logic erase_write_trigger_set_i,
   input wire logic read_trigger_set_i,
   input wire logic unlock_protect_enable_set_i,
   input wire logic erase_write_enabled_clear_i,
   input wire logic flash_addr_high_wr_i,
   input wire logic flash_addr_low_wr_i,
   input wire logic data_low_byte_wr_i,
   input wire logic data_high_byte_wr_i,
   input wire logic [iap_flash_pkg::BYTE_W-1:0] wr_data_i,
   input wire logic aux_data_wr_i,
   input wire logic [2:0] aux_data_sel_i,
   input wire logic [iap_flash_pkg::WORD_W-1:0] fl_rdata_i,
   output logic erase_write_trigger_o,
   output logic read_trigger_o,
   output logic erase_write_enabled_status_o,
   output logic unlock_protect_enable_o,
   output logic [iap_flash_pkg::ADDR_HIGH_W-1:0] flash_addr_high_o,
   output logic [iap_flash_pkg::BYTE_W-1:0] flash_addr_low_o,
   output logic [iap_flash_pkg::BYTE_W-1:0] data_low_byte_reg_o,
   output logic [iap_flash_pkg::BYTE_W-1:0] data_high_byte_reg_o,
   output logic cpu_stall_o,
   output logic [iap_flash_pkg::ADDR_W-1:0] fl_addr_o,
   output logic [iap_flash_pkg::WORD_W-1:0] fl_wdata_o,
   output logic fl_prog_o,
   output logic fl_erase_o,
   output logic fl_read_o
);

   localparam int PW = iap_flash_pkg::PAGE_W;
   localparam int CW = iap_flash_pkg::CNT_W;
   localparam int WW = iap_flash_pkg::WORD_W;
   localparam int PAGE_HI_W = iap_flash_pkg::ADDR_W - PW;
   localparam logic [PW-1:0] LAST_IDX = PW'(BUF_WORDS - 1);

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   if (BUF_WORDS != (1 << PW)) begin : g_bad_buf
      $error("iap_flash_program_control: BUF_WORDS must equal one page");
   end
   if (EW_FAST_CLKS < 1 || EW_FAST_CLKS >= (1 << CW) || EW_SLOW_CLKS < 1 ||
       EW_SLOW_CLKS >= (1 << CW) || UNLOCK_CLKS < 1 || UNLOCK_CLKS >= (1 << CW) ||
       READ_CLKS < 1 || READ_CLKS >= (1 << CW)) begin : g_bad_time
      $error("iap_flash_program_control: timing count out of range");
   end

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   iap_flash_pkg::seq_state_t state;
   logic [WW-1:0] wbuf [BUF_WORDS];
   logic [BUF_WORDS-1:0] buf_valid;
   logic [PW-1:0] buf_ptr;
   logic [PW-1:0] prog_idx;
   logic page_tagged;
   logic [2:0] pat_idx;
   logic pat_bad;
   logic idle;
   logic ew_mode;
   logic ew_go;
   logic rd_go;
   logic prog_last;
   logic op_start;
   logic [CW-1:0] op_count;
   logic op_done;
   logic unlock_start;
   logic unlock_done;
   logic pat_hit;
   logic pat_done;
   logic [PAGE_HI_W-1:0] page_sel;

   function automatic logic mode_is(input logic [2:0] mode, input logic [2:0] code);
      mode_is = (mode == code);
   endfunction

   // ----------------------------------------------------------------
   // Request decode
   // ----------------------------------------------------------------
   assign idle = (state == iap_flash_pkg::ST_IDLE);
   assign page_sel = {flash_addr_high_o, flash_addr_low_o[iap_flash_pkg::BYTE_W-1:PW]};
   assign ew_mode = mode_is(op_mode_field_i, iap_flash_pkg::MODE_WRITE) ||
                    mode_is(op_mode_field_i, iap_flash_pkg::MODE_ERASE);
   assign ew_go = erase_write_trigger_set_i && idle && !erase_write_trigger_o &&
                  erase_write_enabled_status_o && ew_mode &&
                  (page_tagged || !mode_is(op_mode_field_i, iap_flash_pkg::MODE_ERASE));
   assign rd_go = read_trigger_set_i && idle && !read_trigger_o && !ew_go &&
                  mode_is(op_mode_field_i, iap_flash_pkg::MODE_READ) &&
                  read_enable_bit_i;
   assign prog_last = (state == iap_flash_pkg::ST_PROG) && (prog_idx == LAST_IDX);
   assign unlock_start = unlock_protect_enable_set_i &&
                         mode_is(op_mode_field_i, iap_flash_pkg::MODE_UNLOCK);
   assign pat_hit = aux_data_wr_i && unlock_protect_enable_o && (aux_data_sel_i == pat_idx) &&
                    (wr_data_i == iap_flash_pkg::unlock_byte(pat_idx));
   assign pat_done = pat_hit && !pat_bad && (pat_idx == 3'(iap_flash_pkg::UNLOCK_LEN - 1));

   // ----------------------------------------------------------------
   // Operation timer
   // ----------------------------------------------------------------
   always_comb begin
      op_start = (ew_go && mode_is(op_mode_field_i, iap_flash_pkg::MODE_ERASE)) ||
                 prog_last || rd_go;
      if (rd_go) begin
         op_count = CW'(READ_CLKS);
      end else if (erase_write_time_select_i) begin
         op_count = CW'(EW_SLOW_CLKS);
      end else begin
         op_count = CW'(EW_FAST_CLKS);
      end
   end

   cycle_timer #(.CNT_W(CW)) u_op_timer (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .start_i(op_start),
      .count_i(op_count),
      .busy_o(),
      .done_o(op_done)
   );

   cycle_timer #(.CNT_W(CW)) u_unlock_timer (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .start_i(unlock_start),
      .count_i(CW'(UNLOCK_CLKS)),
      .busy_o(),
      .done_o(unlock_done)
   );

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         state <= iap_flash_pkg::ST_IDLE;
         prog_idx <= '0;
      end else begin
         case (state)
            iap_flash_pkg::ST_IDLE: begin
               prog_idx <= '0;
               if (ew_go && mode_is(op_mode_field_i, iap_flash_pkg::MODE_ERASE)) begin
                  state <= iap_flash_pkg::ST_ERASE;
               end else if (ew_go) begin
                  state <= iap_flash_pkg::ST_PROG;
               end else if (rd_go) begin
                  state <= iap_flash_pkg::ST_READ;
               end
            end
            iap_flash_pkg::ST_ERASE: begin
               if (op_done) begin
                  state <= iap_flash_pkg::ST_IDLE;
               end
            end
            iap_flash_pkg::ST_PROG: begin
               prog_idx <= prog_idx + PW'(1);
               if (prog_last) begin
                  state <= iap_flash_pkg::ST_HOLD;
               end
            end
            iap_flash_pkg::ST_HOLD: begin
               if (op_done) begin
                  state <= iap_flash_pkg::ST_IDLE;
               end
            end
            iap_flash_pkg::ST_READ: begin
               if (op_done) begin
                  state <= iap_flash_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= iap_flash_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Trigger bits and CPU stall
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         erase_write_trigger_o <= 1'b0;
         read_trigger_o <= 1'b0;
         cpu_stall_o <= 1'b0;
      end else begin
         if (ew_go) begin
            erase_write_trigger_o <= 1'b1;
         end else if (op_done && state != iap_flash_pkg::ST_READ) begin
            erase_write_trigger_o <= 1'b0;
         end
         if (rd_go) begin
            read_trigger_o <= 1'b1;
         end else if (op_done && state == iap_flash_pkg::ST_READ) begin
            read_trigger_o <= 1'b0;
         end
         if (ew_go || rd_go) begin
            cpu_stall_o <= 1'b1;
         end else if (op_done) begin
            cpu_stall_o <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Flash array strobes
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         fl_addr_o <= '0;
         fl_wdata_o <= '0;
         fl_prog_o <= 1'b0;
         fl_erase_o <= 1'b0;
         fl_read_o <= 1'b0;
      end else begin
         fl_erase_o <= ew_go && mode_is(op_mode_field_i, iap_flash_pkg::MODE_ERASE);
         fl_read_o <= rd_go;
         fl_prog_o <= (state == iap_flash_pkg::ST_PROG) && buf_valid[prog_idx];
         fl_wdata_o <= wbuf[prog_idx];
         if (ew_go && mode_is(op_mode_field_i, iap_flash_pkg::MODE_ERASE)) begin
            fl_addr_o <= {page_sel, PW'(0)};
         end else if (rd_go) begin
            fl_addr_o <= {flash_addr_high_o, flash_addr_low_o};
         end else if (state == iap_flash_pkg::ST_PROG) begin
            fl_addr_o <= {page_sel, prog_idx};
         end
      end
   end

   // ----------------------------------------------------------------
   // Address and data registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         flash_addr_high_o <= '0;
         flash_addr_low_o <= '0;
         data_low_byte_reg_o <= '0;
         data_high_byte_reg_o <= '0;
      end else begin
         if (idle && flash_addr_high_wr_i) begin
            flash_addr_high_o <= wr_data_i[iap_flash_pkg::ADDR_HIGH_W-1:0];
         end
         if (idle && flash_addr_low_wr_i) begin
            flash_addr_low_o <= wr_data_i;
         end
         if (state == iap_flash_pkg::ST_READ && op_done) begin
            data_low_byte_reg_o <= fl_rdata_i[iap_flash_pkg::BYTE_W-1:0];
            data_high_byte_reg_o <= fl_rdata_i[WW-1:iap_flash_pkg::BYTE_W];
         end else begin
            if (idle && data_low_byte_wr_i) begin
               data_low_byte_reg_o <= wr_data_i;
            end
            if (idle && data_high_byte_wr_i) begin
               data_high_byte_reg_o <= wr_data_i;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Write buffer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (idle && data_high_byte_wr_i &&
          mode_is(op_mode_field_i, iap_flash_pkg::MODE_WRITE)) begin
         wbuf[buf_ptr] <= {wr_data_i, data_low_byte_reg_o};
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         buf_valid <= '0;
         buf_ptr <= '0;
         page_tagged <= 1'b0;
      end else begin
         if (idle && buffer_clear_bit_i) begin
            buf_valid <= '0;
            buf_ptr <= flash_addr_low_o[PW-1:0];
         end else if (idle && flash_addr_low_wr_i) begin
            buf_ptr <= wr_data_i[PW-1:0];
         end else if (idle && data_high_byte_wr_i) begin
            if (mode_is(op_mode_field_i, iap_flash_pkg::MODE_WRITE)) begin
               buf_valid[buf_ptr] <= 1'b1;
            end
            if (buf_ptr != LAST_IDX) begin
               buf_ptr <= buf_ptr + PW'(1);
            end
         end
         if (idle && data_high_byte_wr_i &&
             mode_is(op_mode_field_i, iap_flash_pkg::MODE_ERASE)) begin
            page_tagged <= 1'b1;
         end else if (state == iap_flash_pkg::ST_ERASE && op_done) begin
            page_tagged <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Erase/write unlock
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         unlock_protect_enable_o <= 1'b0;
         pat_idx <= '0;
         pat_bad <= 1'b0;
      end else if (unlock_start) begin
         unlock_protect_enable_o <= 1'b1;
         pat_idx <= '0;
         pat_bad <= 1'b0;
      end else begin
         if (unlock_done) begin
            unlock_protect_enable_o <= 1'b0;
         end
         if (aux_data_wr_i && unlock_protect_enable_o) begin
            if (pat_hit && pat_idx != 3'(iap_flash_pkg::UNLOCK_LEN - 1)) begin
               pat_idx <= pat_idx + 3'h1;
            end else if (!pat_hit) begin
               pat_bad <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         erase_write_enabled_status_o <= 1'b0;
      end else if (pat_done) begin
         erase_write_enabled_status_o <= 1'b1;
      end else if (erase_write_enabled_clear_i) begin
         erase_write_enabled_status_o <= 1'b0;
      end
   end

endmodule // iap_flash_program_control

`default_nettype wire

// ---- dv/iap_flash_properties.sv ----
// Port assertions for the flash programming controller.
// Assumes bench timing: fast 20, slow 40, unlock 30, read 12 clocks.
`timescale 1ns/1ps
`default_nettype none
module iap_flash_properties (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic [2:0] op_mode_field_i,
   input wire logic erase_write_time_select_i,
   input wire logic erase_write_enabled_clear_i,
   input wire logic erase_write_trigger_o,
   input wire logic read_trigger_o,
   input wire logic erase_write_enabled_status_o,
   input wire logic unlock_protect_enable_o,
   input wire logic [6:0] flash_addr_high_o,
   input wire logic [7:0] flash_addr_low_o,
   input wire logic cpu_stall_o,
   input wire logic [14:0] fl_addr_o,
   input wire logic fl_prog_o,
   input wire logic fl_erase_o,
   input wire logic fl_read_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   a_stall_on_op: assert property (
      (erase_write_trigger_o || read_trigger_o) |-> cpu_stall_o) else $error("no stall");
   a_ew_needs_enable: assert property (
      $rose(erase_write_trigger_o) |-> $past(erase_write_enabled_status_o))
      else $error("locked op ran");
   a_read_mode_only: assert property (
      $rose(read_trigger_o) |-> $past(op_mode_field_i) == 3'h3) else $error("read mode");
   a_read_timing: assert property (
      $rose(read_trigger_o) |-> fl_read_o ##1 !fl_read_o ##11 read_trigger_o ##1 !read_trigger_o)
      else $error("read timing");
   a_erase_fast_len: assert property (
      $rose(erase_write_trigger_o) && $past(op_mode_field_i) == 3'h1
      && !$past(erase_write_time_select_i) |-> ##20 erase_write_trigger_o ##1 !erase_write_trigger_o)
      else $error("erase length");
   a_write_slow_len: assert property (
      $rose(erase_write_trigger_o) && $past(op_mode_field_i) == 3'h0
      && $past(erase_write_time_select_i) |-> ##104 erase_write_trigger_o ##1 !erase_write_trigger_o)
      else $error("write length");
   a_erase_whole_page: assert property (
      fl_erase_o |-> fl_addr_o[5:0] == 6'h00 && $rose(erase_write_trigger_o)) else $error("erase");
   a_prog_in_page: assert property (
      fl_prog_o |-> fl_addr_o[14:6] == {flash_addr_high_o, flash_addr_low_o[7:6]})
      else $error("page cross");
   a_unlock_window: assert property (
      $rose(unlock_protect_enable_o) |-> ##30 unlock_protect_enable_o ##1 !unlock_protect_enable_o)
      else $error("unlock window");
   a_status_source: assert property (
      $rose(erase_write_enabled_status_o) |-> $past(unlock_protect_enable_o))
      else $error("status set");
   a_enable_drop: assert property (
      erase_write_enabled_clear_i && !unlock_protect_enable_o |=> !erase_write_enabled_status_o)
      else $error("status kept");
endmodule // iap_flash_properties
bind iap_flash_program_control iap_flash_properties u_props (.clk_sys_i(clk_sys_i),
   .srst_i(srst_i), .op_mode_field_i(op_mode_field_i),
   .erase_write_time_select_i(erase_write_time_select_i),
   .erase_write_enabled_clear_i(erase_write_enabled_clear_i),
   .erase_write_trigger_o(erase_write_trigger_o), .read_trigger_o(read_trigger_o),
   .erase_write_enabled_status_o(erase_write_enabled_status_o),
   .unlock_protect_enable_o(unlock_protect_enable_o), .flash_addr_high_o(flash_addr_high_o),
   .flash_addr_low_o(flash_addr_low_o), .cpu_stall_o(cpu_stall_o), .fl_addr_o(fl_addr_o),
   .fl_prog_o(fl_prog_o), .fl_erase_o(fl_erase_o), .fl_read_o(fl_read_o));
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the flash programming controller.
// Assumes the design and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk_sys_i = 1'b0;
   logic srst_i = 1'b1;
   logic [2:0] mode = 3'h0, nm;
   logic ts = 1'b0, rden = 1'b0, nt, nr;
   logic [9:0] stb = 10'h000;
   logic [7:0] wd = 8'h00;
   logic [2:0] sel = 3'h0, ns;
   logic ewt, rdt, ena, prot, stall, prog, ers;
   logic [6:0] ah;
   logic [7:0] al, dl, dh;
   logic [14:0] fa;
   logic [15:0] fw;
   logic [15:0] mem [0:32767];
   int failures = 0;
   int checks = 0;
   always #50 clk_sys_i = ~clk_sys_i;
   iap_flash_program_control #(.EW_FAST_CLKS(20), .EW_SLOW_CLKS(40), .UNLOCK_CLKS(30),
      .READ_CLKS(12)) DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .op_mode_field_i(mode),
      .erase_write_time_select_i(ts), .read_enable_bit_i(rden), .buffer_clear_bit_i(stb[0]),
      .erase_write_trigger_set_i(stb[1]), .read_trigger_set_i(stb[2]),
      .unlock_protect_enable_set_i(stb[3]), .erase_write_enabled_clear_i(stb[4]),
      .flash_addr_high_wr_i(stb[5]), .flash_addr_low_wr_i(stb[6]), .data_low_byte_wr_i(stb[7]),
      .data_high_byte_wr_i(stb[8]), .wr_data_i(wd), .aux_data_wr_i(stb[9]), .aux_data_sel_i(sel),
      .fl_rdata_i(mem[fa]), .erase_write_trigger_o(ewt), .read_trigger_o(rdt),
      .erase_write_enabled_status_o(ena), .unlock_protect_enable_o(prot),
      .flash_addr_high_o(ah), .flash_addr_low_o(al), .data_low_byte_reg_o(dl),
      .data_high_byte_reg_o(dh), .cpu_stall_o(stall), .fl_addr_o(fa), .fl_wdata_o(fw),
      .fl_prog_o(prog), .fl_erase_o(ers), .fl_read_o());
   // ----------------------------------------------------------------
   // Flash array model
   // ----------------------------------------------------------------
   always @(posedge clk_sys_i) begin
      if (ers) for (int i = 0; i < 64; i++) mem[{fa[14:6], i[5:0]}] <= 16'h0000;
      if (prog) mem[fa] <= fw;
   end
   function automatic logic [15:0] iv(input logic [14:0] a);
      return {a[7:0], ~a[14:7]};
   endfunction
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic conclude();
      if (failures == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic poke(input int b, input logic [7:0] d);
      @(posedge clk_sys_i);
      mode <= nm;
      ts <= nt;
      rden <= nr;
      sel <= ns;
      stb <= 10'h001 << b;
      wd <= d;
      @(posedge clk_sys_i);
      stb <= 10'h000;
      @(negedge clk_sys_i);
   endtask
   task automatic idle();
      int n;
      n = 0;
      repeat (2) @(negedge clk_sys_i);
      while (stall !== 1'b0) begin
         @(negedge clk_sys_i);
         n++;
         if (n > 300) begin
            failures++;
            conclude();
         end
      end
   endtask
   task automatic rd(input logic [14:0] a, input logic [15:0] e);
      nm = 3'h3;
      poke(5, {1'b0, a[14:8]});
      poke(6, a[7:0]);
      poke(2, 8'h00);
      idle();
      chk("read data", e, {dh, dl});
   endtask
   task automatic unlock(input logic [7:0] bad);
      logic [7:0] pat [6] = '{8'h00, 8'h0D, 8'hC3, 8'h04, 8'h09, 8'h40};
      nm = 3'h6;
      poke(3, 8'h00);
      for (int i = 0; i < 6; i++) begin
         ns = i[2:0];
         poke(9, pat[i] ^ (i == 3 ? bad : 8'h00));
      end
      @(negedge clk_sys_i);
   endtask
   task automatic load(input logic [15:0] v);
      poke(7, v[7:0]);
      poke(8, v[15:8]);
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [14:0] a;
      logic [15:0] w [5];
      void'($urandom(75327));
      {nm, nt, nr, ns} = 8'h00;
      for (int i = 0; i < 32768; i++) mem[i] = iv(i[14:0]);
      foreach (w[i]) w[i] = $urandom;
      a = $urandom;
      repeat (8) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      @(negedge clk_sys_i);
      chk("idle outputs", 16'h0000, {ewt, rdt, ena, prot, stall});
      rd(a, 16'h0000);
      nr = 1'b1;
      rd(a, iv(a));
      nm = 3'h1;
      poke(8, 8'h00);
      poke(1, 8'h00);
      chk("locked erase", 16'h0000, {ewt, stall});
      unlock(8'hFF);
      chk("bad pattern", 16'h0000, ena);
      repeat (32) @(negedge clk_sys_i);
      unlock(8'h00);
      chk("good pattern", 16'h0001, ena);
      nm = 3'h1;
      poke(0, 8'h00);
      poke(8, 8'h00);
      poke(1, 8'h00);
      idle();
      rd({a[14:6], 6'h05}, 16'h0000);
      {nm, nt} = 4'h1;
      poke(0, 8'h00);
      poke(6, {al[7:6], 6'h3E});
      for (int i = 0; i < 3; i++) load(w[i]);
      poke(1, 8'h00);
      idle();
      rd({a[14:6], 6'h3E}, w[0]);
      rd({a[14:6], 6'h3F}, w[2]);
      rd({a[14:6], 6'h3D}, 16'h0000);
      for (int j = 3; j < 5; j++) begin
         {nm, nt} = 4'h1;
         poke(0, 8'h00);
         poke(6, {al[7:6], 6'h10});
         load(w[j]);
         poke(1, 8'h00);
         idle();
         rd({a[14:6], 6'h10}, w[j]);
      end
      poke(4, 8'h00);
      chk("status cleared", 16'h0000, ena);
      nm = 3'h0;
      poke(1, 8'h00);
      chk("blocked write", 16'h0000, {ewt, stall});
      conclude();
   end
endmodule // testbench
`default_nettype wire
